// [design/vtpc_fifo.sv]
// pixel fifo with valid/ready on both sides
`timescale 1ns/1ps
module vtpc_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // level
  output logic                  full,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;

  assign full      = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign empty     = (wptr == rptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rptr[AW-1:0]];

  always_ff @(posedge pclk) begin
    if (in_valid && !full) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= '0;
    end else if (in_valid && !full) begin
      wptr <= wptr + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rptr <= '0;
    end else if (out_ready && !empty) begin
      rptr <= rptr + 1'b1;
    end
  end

endmodule : vtpc_fifo

// [design/vtpc_map.svh]
// register indices, field positions and reset values of the pattern control block
`ifndef VTPC_MAP_SVH
`define VTPC_MAP_SVH

// direct register indices; byte address is four times the index
`define VTPC_IDX_CFG        8'h65
`define VTPC_IDX_IADDR      8'h66
`define VTPC_IDX_IDATA      8'h67
`define VTPC_IDX_STATUS     8'h68

// configuration fields
`define VTPC_CFG_AUTO       0
`define VTPC_CFG_INVERT     1
`define VTPC_CFG_TSEL       2
`define VTPC_CFG_EXTCLK     3
`define VTPC_CFG_MODE18     4
`define VTPC_CFG_CHKSCALE   6
`define VTPC_CFG_RESET      8'h00
`define VTPC_CFG_MASK       8'h5f
`define VTPC_IADDR_RESET    8'h00

// status fields
`define VTPC_ST_PAT_LSB     0
`define VTPC_ST_INTERNAL    3
`define VTPC_ST_FULL        4
`define VTPC_ST_EMPTY       5

// indirect register map
`define VTPC_IND_COUNT      16
`define VTPC_IND_FT         4'h0
`define VTPC_IND_PEN        4'h1
`define VTPC_IND_PSEL       4'h2
`define VTPC_IND_HTOT_L     4'h3
`define VTPC_IND_HTOT_H     4'h4
`define VTPC_IND_VTOT_L     4'h5
`define VTPC_IND_VTOT_H     4'h6
`define VTPC_IND_HACT_L     4'h7
`define VTPC_IND_HACT_H     4'h8
`define VTPC_IND_VACT_L     4'h9
`define VTPC_IND_VACT_H     4'ha
`define VTPC_IND_HSW        4'hb
`define VTPC_IND_VSW        4'hc
`define VTPC_IND_HBP        4'hd
`define VTPC_IND_VBP        4'he
`define VTPC_IND_SYNC       4'hf
`define VTPC_IND_FT_RESET   8'h01
`define VTPC_IND_PEN_RESET  8'hff
`define VTPC_IND_RESET      8'h00

// sync configuration fields
`define VTPC_SYNC_HS_POL    0
`define VTPC_SYNC_VS_POL    1

// internal pixel clock divider default
`define VTPC_CLK_DIV        2

`endif

// [design/vtpc_pkg.sv]
// types shared by the pattern control block
package vtpc_pkg;

  typedef struct packed {
    logic        de;
    logic        hs;
    logic        vs;
    logic [23:0] rgb;
  } vtpc_pix_t;

  typedef struct packed {
    logic [11:0] htot;
    logic [11:0] vtot;
    logic [11:0] hact;
    logic [11:0] vact;
    logic [7:0]  hsw;
    logic [7:0]  vsw;
    logic [7:0]  hbp;
    logic [7:0]  vbp;
    logic        hs_pol;
    logic        vs_pol;
  } vtpc_timing_t;

  typedef enum logic [2:0] {
    PAT_WHITE,
    PAT_BLACK,
    PAT_RED,
    PAT_GREEN,
    PAT_BLUE,
    PAT_HRAMP,
    PAT_VRAMP,
    PAT_CHECKER
  } vtpc_pat_t;

endpackage : vtpc_pkg

// [design/vtpc_top.sv]
// video test pattern control with apb registers and indirect settings port
`timescale 1ns/1ps
`include "vtpc_map.svh"
module vtpc_top
  import vtpc_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int CLK_DIV    = `VTPC_CLK_DIV
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // external video timing and pixel strobe
  input  wire vtpc_pix_t   ext_pix,
  input  wire logic        ext_valid,
  output logic             ext_ready,
  input  wire logic        ext_pix_stb,
  // pattern output stream
  output vtpc_pix_t        out_pix,
  output logic             out_valid,
  input  wire logic        out_ready
);
  localparam int DIV_W = (CLK_DIV > 1) ? $clog2(CLK_DIV) : 1;
  localparam int NPAT  = 8;

  if (CLK_DIV < 1 || CLK_DIV > 256) begin : g_chk_div
    $error("clock divider must lie between 1 and 256");
  end

  // ---------------- register bus ----------------
  logic [7:0] cfg;
  logic [7:0] iaddr;
  logic [7:0] ind [0:`VTPC_IND_COUNT-1];
  logic [7:0] idx;
  logic       mapped;
  logic       acc_wr;
  logic       setup;
  logic [7:0] ind_rd;
  logic [7:0] status;
  logic [7:0] rd_mux;
  logic       advance;
  logic [2:0] next_pat;
  logic       fifo_full;
  logic       fifo_empty;

  assign idx    = paddr[9:2];
  assign mapped = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
                  ((idx == `VTPC_IDX_CFG) || (idx == `VTPC_IDX_IADDR) ||
                   (idx == `VTPC_IDX_IDATA) || (idx == `VTPC_IDX_STATUS));
  assign setup  = psel && !penable;
  assign acc_wr = psel && penable && pwrite && mapped;
  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= `VTPC_CFG_RESET;
    end else if (acc_wr && idx == `VTPC_IDX_CFG) begin
      cfg <= pwdata[7:0] & `VTPC_CFG_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iaddr <= `VTPC_IADDR_RESET;
    end else if (acc_wr && idx == `VTPC_IDX_IADDR) begin
      iaddr <= pwdata[7:0];
    end
  end

  // one flop group per indirect entry; software write wins over auto advance
  for (genvar i = 0; i < `VTPC_IND_COUNT; i++) begin : g_ind
    localparam logic [7:0] RST = (i == `VTPC_IND_FT)  ? `VTPC_IND_FT_RESET :
                                 (i == `VTPC_IND_PEN) ? `VTPC_IND_PEN_RESET :
                                                        `VTPC_IND_RESET;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ind[i] <= RST;
      end else if (acc_wr && idx == `VTPC_IDX_IDATA && iaddr == 8'(i)) begin
        ind[i] <= pwdata[7:0];
      end else if (i == `VTPC_IND_PSEL && advance) begin
        ind[i] <= {5'h0_0, next_pat};
      end
    end
  end

  // addresses beyond the indirect map read as zero
  assign ind_rd = (iaddr < 8'(`VTPC_IND_COUNT)) ? ind[iaddr[3:0]] : 8'h00;

  always_comb begin
    status = 8'h00;
    status[`VTPC_ST_PAT_LSB +: 3] = ind[`VTPC_IND_PSEL][2:0];
    status[`VTPC_ST_INTERNAL]     = cfg[`VTPC_CFG_TSEL];
    status[`VTPC_ST_FULL]         = fifo_full;
    status[`VTPC_ST_EMPTY]        = fifo_empty;
  end

  always_comb begin
    rd_mux = 8'h00;
    if (mapped) begin
      unique case (idx)
        `VTPC_IDX_CFG:    rd_mux = cfg;
        `VTPC_IDX_IADDR:  rd_mux = iaddr;
        `VTPC_IDX_IDATA:  rd_mux = ind_rd;
        `VTPC_IDX_STATUS: rd_mux = status;
        default:          rd_mux = 8'h00;
      endcase
    end
  end

  // read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= {24'h00_0000, rd_mux};
    end
  end

  // ---------------- timing settings ----------------
  vtpc_timing_t tm;
  logic         tsel;
  logic         auto_scroll;

  assign tsel        = cfg[`VTPC_CFG_TSEL];
  assign auto_scroll = cfg[`VTPC_CFG_AUTO];

  always_comb begin
    tm.htot   = {ind[`VTPC_IND_HTOT_H][3:0], ind[`VTPC_IND_HTOT_L]};
    tm.vtot   = {ind[`VTPC_IND_VTOT_H][3:0], ind[`VTPC_IND_VTOT_L]};
    tm.hact   = {ind[`VTPC_IND_HACT_H][3:0], ind[`VTPC_IND_HACT_L]};
    tm.vact   = {ind[`VTPC_IND_VACT_H][3:0], ind[`VTPC_IND_VACT_L]};
    tm.hsw    = ind[`VTPC_IND_HSW];
    tm.vsw    = ind[`VTPC_IND_VSW];
    tm.hbp    = ind[`VTPC_IND_HBP];
    tm.vbp    = ind[`VTPC_IND_VBP];
    tm.hs_pol = ind[`VTPC_IND_SYNC][`VTPC_SYNC_HS_POL];
    tm.vs_pol = ind[`VTPC_IND_SYNC][`VTPC_SYNC_VS_POL];
  end

  // ---------------- internal timing generator ----------------
  logic [DIV_W-1:0] divcnt;
  logic             div_tick;
  logic             pix_tick;
  logic             fifo_in_ready;
  logic             fifo_in_valid;
  logic             gen_acc;
  logic             ext_acc;
  logic [11:0]      hcnt;
  logic [11:0]      vcnt;
  logic             h_wrap;
  logic             v_wrap;
  logic [12:0]      hstart;
  logic [12:0]      vstart;
  logic             gen_de;

  assign div_tick = (divcnt == DIV_W'(CLK_DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divcnt <= '0;
    end else if (div_tick) begin
      divcnt <= '0;
    end else begin
      divcnt <= divcnt + 1'b1;
    end
  end

  // pixel source only matters under internal timing
  assign pix_tick      = cfg[`VTPC_CFG_EXTCLK] ? ext_pix_stb : div_tick;
  assign fifo_in_valid = tsel ? pix_tick : ext_valid;
  assign gen_acc       = tsel && pix_tick && fifo_in_ready;
  assign ext_acc       = !tsel && ext_valid && fifo_in_ready;
  // external stream is drained while unused so its source never hangs
  assign ext_ready     = tsel ? 1'b1 : fifo_in_ready;

  assign h_wrap = ({1'b0, hcnt} + 13'h0001) >= {1'b0, tm.htot};
  assign v_wrap = ({1'b0, vcnt} + 13'h0001) >= {1'b0, tm.vtot};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt <= 12'h000;
      vcnt <= 12'h000;
    end else if (gen_acc) begin
      if (h_wrap) begin
        hcnt <= 12'h000;
        vcnt <= v_wrap ? 12'h000 : vcnt + 12'h001;
      end else begin
        hcnt <= hcnt + 12'h001;
      end
    end
  end

  assign hstart = 13'(tm.hsw) + 13'(tm.hbp);
  assign vstart = 13'(tm.vsw) + 13'(tm.vbp);
  assign gen_de = ({1'b0, hcnt} >= hstart) && ({1'b0, hcnt} < hstart + {1'b0, tm.hact}) &&
                  ({1'b0, vcnt} >= vstart) && ({1'b0, vcnt} < vstart + {1'b0, tm.vact});

  // ---------------- external timing position ----------------
  logic [11:0] ex;
  logic [11:0] ey;
  logic        prev_de;
  logic        prev_vs;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ex      <= 12'h000;
      ey      <= 12'h000;
      prev_de <= 1'b0;
      prev_vs <= 1'b0;
    end else if (ext_acc) begin
      prev_de <= ext_pix.de;
      prev_vs <= ext_pix.vs;
      if (ext_pix.vs) begin
        ex <= 12'h000;
        ey <= 12'h000;
      end else if (ext_pix.de) begin
        ex <= ex + 12'h001;
      end else if (prev_de) begin
        ex <= 12'h000;
        ey <= ey + 12'h001;
      end
    end
  end

  // ---------------- pattern colour ----------------
  logic [11:0] px;
  logic [11:0] py;
  logic        chk;
  logic [23:0] base_rgb;
  logic [23:0] col_rgb;
  vtpc_pix_t   gen_pix;

  assign px  = tsel ? 12'(13'(hcnt) - hstart) : ex;
  assign py  = tsel ? 12'(13'(vcnt) - vstart) : ey;
  assign chk = cfg[`VTPC_CFG_CHKSCALE] ? (px[3] ^ py[3]) : (px[0] ^ py[0]);

  always_comb begin
    unique case (vtpc_pat_t'(ind[`VTPC_IND_PSEL][2:0]))
      PAT_WHITE:   base_rgb = 24'hff_ffff;
      PAT_BLACK:   base_rgb = 24'h00_0000;
      PAT_RED:     base_rgb = 24'hff_0000;
      PAT_GREEN:   base_rgb = 24'h00_ff00;
      PAT_BLUE:    base_rgb = 24'h00_00ff;
      PAT_HRAMP:   base_rgb = {3{px[7:0]}};
      PAT_VRAMP:   base_rgb = {3{py[7:0]}};
      PAT_CHECKER: base_rgb = chk ? 24'hff_ffff : 24'h00_0000;
    endcase
  end

  always_comb begin
    col_rgb = cfg[`VTPC_CFG_INVERT] ? ~base_rgb : base_rgb;
    // 18-bit mode keeps only the six upper bits of each colour
    if (cfg[`VTPC_CFG_MODE18]) begin
      col_rgb = col_rgb & 24'hfc_fcfc;
    end
  end

  always_comb begin
    if (tsel) begin
      gen_pix.de  = gen_de;
      gen_pix.hs  = ({4'h0, hcnt} < 16'(tm.hsw)) ^ tm.hs_pol;
      gen_pix.vs  = ({4'h0, vcnt} < 16'(tm.vsw)) ^ tm.vs_pol;
      gen_pix.rgb = gen_de ? col_rgb : 24'h00_0000;
    end else begin
      gen_pix.de  = ext_pix.de;
      gen_pix.hs  = ext_pix.hs;
      gen_pix.vs  = ext_pix.vs;
      gen_pix.rgb = ext_pix.de ? col_rgb : 24'h00_0000;
    end
  end

  // ---------------- auto scroll ----------------
  logic       frame_end;
  logic [7:0] fcnt;
  logic       ft_done;

  assign frame_end = (gen_acc && h_wrap && v_wrap) ||
                     (ext_acc && ext_pix.vs && !prev_vs);
  // a frame time of zero behaves as one frame
  assign ft_done   = ({1'b0, fcnt} + 9'h001) >= {1'b0, ind[`VTPC_IND_FT]};
  assign advance   = auto_scroll && frame_end && ft_done;

  function automatic logic [2:0] find_next(input logic [2:0] cur, input logic [7:0] en);
    logic [2:0] cand;
    logic       hit;
    find_next = cur;
    hit       = 1'b0;
    for (int k = 1; k < NPAT; k++) begin
      cand = cur + 3'(k);
      if (!hit && en[cand]) begin
        find_next = cand;
        hit       = 1'b1;
      end
    end
  endfunction : find_next

  assign next_pat = find_next(ind[`VTPC_IND_PSEL][2:0], ind[`VTPC_IND_PEN]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt <= 8'h00;
    end else if (!auto_scroll) begin
      fcnt <= 8'h00;
    end else if (frame_end) begin
      fcnt <= ft_done ? 8'h00 : fcnt + 8'h01;
    end
  end

  // ---------------- output buffer ----------------
  logic [$bits(vtpc_pix_t)-1:0] fifo_out;

  vtpc_fifo #(
    .WIDTH ($bits(vtpc_pix_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (gen_pix),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out),
    .full      (fifo_full),
    .empty     (fifo_empty)
  );

  assign out_pix = vtpc_pix_t'(fifo_out);

endmodule : vtpc_top

// [sim/tb_video_test_pattern_control.sv]
// self-checking bench for the pattern control block
`timescale 1ns/1ps
`include "vtpc_map.svh"
module tb_video_test_pattern_control
  import vtpc_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        ext_valid = 1'b0;
  logic        out_ready = 1'b0;
  logic        ext_pix_stb = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_ready;
  logic        out_valid;
  vtpc_pix_t   ext_pix = '0;
  vtpc_pix_t   out_pix;
  logic [7:0]  rv;
  logic        err;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          n;
  int          nde;
  // small frame: 20x6 total, 8x2 active
  logic [7:0]  tim [3:14] = '{8'h14, 8'h00, 8'h06, 8'h00, 8'h08, 8'h00,
                             8'h02, 8'h00, 8'h02, 8'h01, 8'h02, 8'h01};
  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

  always #10 pclk = ~pclk;

  vtpc_top DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_pix(ext_pix), .ext_valid(ext_valid), .ext_ready(ext_ready), .ext_pix_stb(ext_pix_stb),
    .out_pix(out_pix), .out_valid(out_valid), .out_ready(out_ready)
  );

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until ready is seen at a rising edge; only the watchdog ends a hang
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    rv      = prdata[7:0];
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    apb(1'b0, idx, 8'h00);
  endtask : rd

  task automatic ind(input logic [7:0] a, input logic [7:0] d);
    wr(`VTPC_IDX_IADDR, a);
    wr(`VTPC_IDX_IDATA, d);
  endtask : ind

  task automatic push(input logic vs);
    @(posedge pclk);
    ext_pix   <= '{de: 1'b1, hs: 1'b1, vs: vs, rgb: 24'h12_3456};
    ext_valid <= 1'b1;
    @(posedge pclk);
    while (!ext_ready) @(posedge pclk);
    ext_valid <= 1'b0;
  endtask : push

  // pops everything; n counts pixels taken at rising edges
  task automatic drain;
    @(posedge pclk);
    out_ready <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (out_valid) begin
      n++;
      @(posedge pclk);
    end
    out_ready <= 1'b0;
  endtask : drain

  task automatic conclude;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(`VTPC_IDX_IADDR);
    `CHK(rv, 8'h00)
    rd(`VTPC_IDX_CFG);
    `CHK(rv, 8'h00)
    rd(`VTPC_IDX_IDATA);
    `CHK(rv, 8'h01)
    wr(`VTPC_IDX_IADDR, 8'ha5);
    rd(`VTPC_IDX_IADDR);
    `CHK(rv, 8'ha5)
    for (int i = 3; i < 15; i++) ind(8'(i), tim[i]);
    for (int i = 3; i < 15; i++) begin
      wr(`VTPC_IDX_IADDR, 8'(i));
      rd(`VTPC_IDX_IDATA);
      `CHK(rv, tim[i])
    end
    ind(8'h20, 8'h77);
    rd(`VTPC_IDX_IDATA);
    `CHK(rv, 8'h00)
    rd(8'h40);
    `CHK({err, rv}, 9'h100)
    wr(`VTPC_IDX_STATUS, 8'hff);
    rd(`VTPC_IDX_STATUS);
    `CHK({err, rv}, 9'h020)
    // clock source bit must not matter with external timing
    wr(`VTPC_IDX_CFG, 8'h08);
    for (int j = 0; j < 2; j++) begin
      push(1'b0);
      @(negedge pclk);
      `CHK(out_valid, 1'b1)
      `CHK(out_pix, {3'b110, j ? 24'h00_0000 : 24'hff_ffff})
      drain();
      wr(`VTPC_IDX_CFG, 8'h0a);
    end
    wr(`VTPC_IDX_CFG, 8'h00);
    @(posedge pclk);
    ext_valid <= 1'b1;
    n = 0;
    repeat (12) begin
      @(negedge pclk);
      if (ext_ready) n++;
    end
    @(posedge pclk);
    ext_valid <= 1'b0;
    `CHK(n, 8)
    rd(`VTPC_IDX_STATUS);
    `CHK(rv, 8'h10)
    drain();
    `CHK(n, 8)
    ind(8'h01, 8'h05);
    ind(8'h00, 8'h02);
    wr(`VTPC_IDX_CFG, 8'h01);
    for (int f = 0; f < 4; f++) begin
      push(1'b0);
      push(1'b1);
      rd(`VTPC_IDX_STATUS);
      `CHK(rv[2:0], (f == 0) ? 3'h0 : 3'h2)
      if (f == 1) wr(`VTPC_IDX_CFG, 8'h00);
    end
    drain();
    `CHK(n, 8)
    // ext clock bit under internal timing: pixels only on the strobe
    wr(`VTPC_IDX_CFG, 8'h0c);
    @(posedge pclk);
    out_ready <= 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge pclk);
      if (out_valid) n++;
    end
    `CHK(n, 0)
    ext_pix_stb <= 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge pclk);
      if (out_valid) n++;
    end
    ext_pix_stb <= 1'b0;
    `CHK(n, 39)
    // internal timing: 16 active pixels per 240-cycle frame; sink kept ready, no backlog
    wr(`VTPC_IDX_CFG, 8'h04);
    rd(`VTPC_IDX_STATUS);
    `CHK(rv[3], 1'b1)
    @(posedge pclk);
    out_ready <= 1'b1;
    n = 0;
    nde = 0;
    repeat (2400) begin
      @(negedge pclk);
      if (out_valid) n++;
      // red stays selected after the auto scroll scenario
      if (out_valid && out_pix.de && out_pix.rgb == 24'hff_0000) nde++;
    end
    @(posedge pclk);
    out_ready <= 1'b0;
    `CHK(n >= 1195 && n <= 1205, 1'b1)
    `CHK(nde >= 144 && nde <= 176, 1'b1)
    conclude();
  end

  initial begin
    #(20000 * 20);
    n_mismatch++;
    conclude();
  end
endmodule : tb_video_test_pattern_control

// [sim/vtpc_checker.sv]
// port-level assertions for the pattern control block
`timescale 1ns/1ps
module vtpc_checker
  import vtpc_pkg::*;
(
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // video
  input wire vtpc_pix_t   ext_pix,
  input wire logic        ext_valid,
  input wire logic        ext_ready,
  input wire logic        ext_pix_stb,
  input wire vtpc_pix_t   out_pix,
  input wire logic        out_valid,
  input wire logic        out_ready
);
  logic hit;
  assign hit = paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00 &&
               paddr[9:2] >= 8'h65 && paddr[9:2] <= 8'h68;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access without ready");
  a_err_decode: assert property (psel && penable |-> pslverr == !hit)
    else $error("error flag disagrees with decode");
  a_err_access_only: assert property (pslverr |-> psel && penable)
    else $error("error flag outside access");
  a_read_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  a_read_stands: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  a_unmapped_zero: assert property (psel && penable && !pwrite && !hit |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_pix))
    else $error("stalled pixel changed");
  a_refuse_full: assert property (!ext_ready |-> out_valid)
    else $error("refused while empty");
  c_write: cover property (psel && penable && pwrite);
  c_unmapped: cover property (pslverr);
  c_stall: cover property (out_valid && !out_ready ##1 out_valid && !out_ready);
  c_refuse: cover property (ext_valid && !ext_ready);
endmodule : vtpc_checker

bind vtpc_top vtpc_checker u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_pix(ext_pix), .ext_valid(ext_valid), .ext_ready(ext_ready),
  .ext_pix_stb(ext_pix_stb), .out_pix(out_pix), .out_valid(out_valid), .out_ready(out_ready)
);
